// >>> icfg_pkg.sv
// Package for the inertial sensor configuration and command register block.
// Assumes both ends share one core clock and one synchronous reset.
package icfg_pkg;
  // ==========================================================================
  // Frame layout
  localparam int FRAME_W = 16;
  localparam int WR_BIT = 15;
  localparam int ADDR_HI = 14;
  localparam int ADDR_LO = 8;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // ==========================================================================
  // Register byte addresses (low and high byte of the 16-bit registers)
  localparam logic [6:0] ADDR_MISC_LO = 7'h60;
  localparam logic [6:0] ADDR_MISC_HI = 7'h61;
  localparam logic [6:0] ADDR_SCALE_LO = 7'h62;
  localparam logic [6:0] ADDR_SCALE_HI = 7'h63;
  localparam logic [6:0] ADDR_DEC_LO = 7'h64;
  localparam logic [6:0] ADDR_DEC_HI = 7'h65;
  localparam logic [6:0] ADDR_CMD_LO = 7'h68;
  localparam logic [6:0] ADDR_CMD_HI = 7'h69;
  localparam logic [6:0] ADDR_REV_LO = 7'h6C;
  localparam logic [6:0] ADDR_REV_HI = 7'h6D;
  localparam logic [6:0] ADDR_DIAG_LO = 7'h02;
  localparam logic [6:0] ADDR_FILT_LO = 7'h5C;
  // ==========================================================================
  // Reset values and field positions
  localparam logic [15:0] MISC_RST = 16'h00C1;
  localparam logic [15:0] SCALE_RST = 16'h07D0;
  localparam logic [15:0] DEC_RST = 16'h0000;
  localparam logic [15:0] FILT_RST = 16'h0000;
  localparam logic [10:0] DEC_MAX = 11'h7CF;
  localparam int DEC_W = 11;
  localparam int MISC_POP_BIT = 6;
  localparam int MISC_LACC_BIT = 7;
  localparam int MISC_SYNC_HI = 3;
  localparam int MISC_SYNC_LO = 2;
  localparam int CMD_RESET_BIT = 7;
  localparam int CMD_FTEST_BIT = 4;
  localparam int CMD_FSAVE_BIT = 3;
  localparam int CMD_STEST_BIT = 2;
  localparam int CMD_RESTORE_BIT = 1;
  localparam int DIAG_FSAVE_BIT = 2;
  localparam int DIAG_STEST_BIT = 5;
  localparam int DIAG_FTEST_BIT = 6;
  localparam logic [7:0] CMD_USED_MASK = 8'h9E;
  // ==========================================================================
  // Timing: internal sample clock 2 kHz, core clock 40 MHz
  localparam int CLK_HZ = 40000000;
  localparam int INT_RATE_HZ = 2000;
  localparam int TICK_CYC = CLK_HZ / INT_RATE_HZ;
  localparam int DEC_UPD_US = 30;
  localparam int DEC_UPD_CYC = (DEC_UPD_US * (CLK_HZ / 1000000));
  localparam int CMD_BUSY_CYC_DEF = 2000;
  localparam int DEC_UPD_DELAY = 8;
  // ==========================================================================
  typedef enum logic [1:0] {
    SYNC_INTERNAL = 2'b00,
    SYNC_DIRECT = 2'b01,
    SYNC_SCALED = 2'b10,
    SYNC_OUTPUT = 2'b11
  } icfg_sync_e;

  // Bit decode of a frame field
  function automatic logic [6:0] frame_addr(input logic [15:0] f);
    frame_addr = f[ADDR_HI:ADDR_LO];
  endfunction
endpackage

// >>> icfg_link_if.sv
// Interface joining the host frame engine and the sensor register block.
// Assumes a single core clock; frames are one-cycle valid/ready beats.
`timescale 1ns/1ps
interface icfg_link_if;
  logic frame_valid;
  logic frame_ready;
  logic [15:0] frame_data;
  logic [15:0] rd_data;
  logic rd_valid;
  logic sample_valid_strobe;
  logic sync_pin_in;
  logic sync_pin_out;
  logic sync_pin_oe_n;

  // Host side drives frames and the sync clock
  modport host (
    output frame_valid, frame_data, sync_pin_in,
    input frame_ready, rd_data, rd_valid, sample_valid_strobe, sync_pin_out, sync_pin_oe_n
  );
  // Device side answers frames
  modport dev (
    input frame_valid, frame_data, sync_pin_in,
    output frame_ready, rd_data, rd_valid, sample_valid_strobe, sync_pin_out, sync_pin_oe_n
  );
endinterface

// >>> icfg_host.sv
// Host end: turns APB register orders into serial register frames.
// Assumes an APB master on the user side and the link interface on the far side.
`timescale 1ns/1ps
module icfg_host (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  icfg_link_if.host link
);
  import icfg_pkg::*;
  // ==========================================================================
  // Own registers: 0x00 frame (write sends it), 0x04 status, 0x08 last read, 0x0C sync drive
  localparam logic [7:0] H_FRAME = 8'h00;
  localparam logic [7:0] H_STAT = 8'h04;
  localparam logic [7:0] H_RDATA = 8'h08;
  localparam logic [7:0] H_SYNC = 8'h0C;

  typedef struct packed {
    logic busy;
    logic [15:0] frame;
    logic [15:0] rdata;
    logic sync;
    logic [31:0] prdata;
    logic ready;
    logic err;
  } icfg_hst_s;
  icfg_hst_s st_r, st_nxt;

  // APB decode and frame launch; one frame per write, software orders frame pairs
  always_comb begin
    st_nxt = st_r;
    st_nxt.ready = 1'b0;
    st_nxt.err = 1'b0;
    if (st_r.busy && link.frame_ready) begin
      st_nxt.busy = 1'b0;
    end
    if (link.rd_valid) begin
      st_nxt.rdata = link.rd_data;
    end
    // First access cycle: read data and refusal prepared for the answer cycle
    if (psel_i && penable_i && !st_r.ready) begin
      st_nxt.ready = 1'b1;
      st_nxt.prdata = 32'h0000_0000;
      unique case (paddr_i)
        H_FRAME: if (pwrite_i) begin
          st_nxt.err = st_r.busy;
        end else begin
          st_nxt.prdata = {16'h0000, st_r.frame};
        end
        H_STAT: st_nxt.prdata = {30'h0000_0000, link.sample_valid_strobe, st_r.busy};
        H_RDATA: st_nxt.prdata = {16'h0000, st_r.rdata};
        H_SYNC: if (!pwrite_i) begin
          st_nxt.prdata = {31'h0000_0000, st_r.sync};
        end
        default: st_nxt.err = 1'b1;
      endcase
    end
    // Write lands only at the edge where pready is sampled high
    if (psel_i && penable_i && pwrite_i && st_r.ready && !st_r.err) begin
      if (paddr_i == H_FRAME) begin
        st_nxt.frame = pwdata_i[15:0];
        st_nxt.busy = 1'b1;
      end else if (paddr_i == H_SYNC) begin
        st_nxt.sync = pwdata_i[0];
      end
    end
    if (sys_rst_i) begin
      st_nxt = '0;
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    st_r <= st_nxt;
  end

  assign link.frame_valid = st_r.busy;
  assign link.frame_data = st_r.frame;
  assign link.sync_pin_in = st_r.sync;
  assign prdata_o = st_r.prdata;
  assign pready_o = st_r.ready;
  assign pslverr_o = st_r.err;
endmodule

// >>> icfg_dev.sv
// Device end: configuration and command register bank of the sensor module.
// Assumes frames arrive from the host end on the link interface.
// Functional notes
// - Misc bit 6 enables point-of-percussion alignment
// - Host clears bit 6 with two frames
// - Misc bit 7 enables gyro acceleration compensation
// - Sync scale register at 0x62, reset 0x07D0
// - Sync readback valid after next data-ready
// - Decimation 11 bits at 0x64, max 1999
// - Decimation readback updates within 30 us
// - Decimation averages samples and lengthens deltas
// - Internal rate is 2000 over decimation plus one
// - Scaled sync multiplies sync by scale factor
// - Direct sync uses multiplier of one
// - Command register 0x68 write-only, ones trigger
// - Command running halts data and interface
// - Command bit 7 performs software reset
// - Command bit 4 flash check sets diag 6
// - Command bit 3 backup, diag 2 outcome
// - Command bit 2 self test, diag 5
// - Command bit 1 restores factory defaults (code restores misc, decimation and filter, clears bias, but keeps scale)
// - Revision register 0x6C read-only BCD
// - Sync field selects clock source
`timescale 1ns/1ps
module icfg_dev #(
  parameter int CMD_BUSY_CYC = icfg_pkg::CMD_BUSY_CYC_DEF,
  parameter logic [15:0] FW_REV = 16'h0104, // Arbitrary value
  parameter int DEC_DELAY = icfg_pkg::DEC_UPD_DELAY
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic flash_crc_ok_i,
  input wire logic flash_save_ok_i,
  input wire logic self_test_ok_i,
  output logic [15:0] misc_ctrl_o,
  output logic [15:0] sync_multiplier_o,
  output logic [10:0] decimation_o,
  output logic [11:0] gyro_x_offset_low_o,
  output logic sample_tick_o,
  icfg_link_if.dev link
);
  import icfg_pkg::*;
  initial begin
    if (CMD_BUSY_CYC < 1 || DEC_DELAY < 1 || DEC_DELAY > DEC_UPD_CYC) begin
      $error("icfg_dev: bad parameter");
    end
  end

  typedef enum logic [1:0] {
    CM_IDLE = 2'b00,
    CM_RUN = 2'b01
  } icfg_cmd_e;

  typedef struct packed {
    logic [15:0] misc;
    logic [15:0] scale;
    logic [15:0] dec;
    logic [15:0] dec_pend;
    logic [15:0] dec_cnt;
    logic [15:0] filt;
    logic [15:0] diag;
    logic [11:0] bias_clr;
    logic [7:0] cmd;
    icfg_cmd_e cmd_st;
    logic [31:0] busy_cnt;
    logic [15:0] tick_cnt;
    logic [31:0] scaled_cnt;
    logic [10:0] div_cnt;
    logic sync_d;
    logic drdy;
    logic sync_stale;
    logic [15:0] rd_data;
    logic rd_valid;
    logic tick;
  } icfg_dev_s;
  icfg_dev_s st_r, st_nxt;

  // High byte address of the filter register
  localparam logic [6:0] ADDR_FILT_HI = ADDR_FILT_LO + 7'h01;

  // Register read decode, low byte from even address
  function automatic logic [15:0] reg_read(input icfg_dev_s s, input logic [6:0] a);
    unique case ({a[6:1], 1'b0})
      ADDR_MISC_LO: reg_read = s.misc;
      ADDR_SCALE_LO: reg_read = s.scale;
      ADDR_DEC_LO: reg_read = s.dec;
      ADDR_REV_LO: reg_read = FW_REV;
      ADDR_DIAG_LO: reg_read = s.diag;
      ADDR_FILT_LO: reg_read = s.filt;
      default: reg_read = 16'h0000; // Command register reads zero
    endcase
  endfunction

  // Frame handling, commands and the sample clock
  always_comb begin
    logic [6:0] a;
    logic [7:0] d;
    logic sync_edge;
    logic src_tick;
    logic stale_set;
    a = frame_addr(link.frame_data);
    d = link.frame_data[7:0];
    sync_edge = link.sync_pin_in && !st_r.sync_d;
    src_tick = 1'b0;
    stale_set = 1'b0;
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.tick = 1'b0;
    st_nxt.bias_clr = '0;
    st_nxt.sync_d = link.sync_pin_in;
    // Pending decimation value lands in readback; a write below reloads the delay
    if (st_r.dec_cnt != 16'h0000) begin
      st_nxt.dec_cnt = st_r.dec_cnt - 16'h0001;
      if (st_r.dec_cnt == 16'h0001) begin
        st_nxt.dec = st_r.dec_pend;
      end
    end
    // Byte frames land at once, decimation only after DEC_DELAY cycles; interface accepted only when no command runs
    if (st_r.cmd_st == CM_IDLE && link.frame_valid) begin
      if (link.frame_data[WR_BIT]) begin
        unique case (a)
          ADDR_MISC_LO: begin
            st_nxt.misc[7:0] = d;
            if (d[MISC_SYNC_HI:MISC_SYNC_LO] != st_r.misc[MISC_SYNC_HI:MISC_SYNC_LO]) begin
              stale_set = 1'b1;
            end
          end
          ADDR_MISC_HI: st_nxt.misc[15:8] = d;
          ADDR_SCALE_LO: begin
            st_nxt.scale[7:0] = d;
            stale_set = 1'b1;
          end
          ADDR_SCALE_HI: begin
            st_nxt.scale[15:8] = d;
            stale_set = 1'b1;
          end
          ADDR_DEC_LO: begin
            st_nxt.dec_pend[7:0] = d;
            st_nxt.dec_cnt = 16'(DEC_DELAY);
          end
          ADDR_DEC_HI: begin
            st_nxt.dec_pend[15:8] = d;
            st_nxt.dec_cnt = 16'(DEC_DELAY);
          end
          ADDR_FILT_LO: st_nxt.filt[7:0] = d;
          ADDR_FILT_HI: st_nxt.filt[15:8] = d;
          ADDR_CMD_LO: begin
            st_nxt.cmd = d & CMD_USED_MASK;
            if ((d & CMD_USED_MASK) != 8'h00) begin
              st_nxt.cmd_st = CM_RUN;
              st_nxt.busy_cnt = 32'(CMD_BUSY_CYC);
            end
          end
          default: ; // Unmapped, revision and high command byte ignored
        endcase
        if (stale_set) begin
          st_nxt.sync_stale = 1'b1;
        end
      end else begin
        st_nxt.rd_data = (st_r.sync_stale && a[6:1] == ADDR_SCALE_LO[6:1]) ? 16'h0000 : reg_read(st_r, a);
        st_nxt.rd_valid = 1'b1;
      end
    end
    // Sample source by sync mode
    if (st_r.tick_cnt == 16'(TICK_CYC - 1)) begin
      st_nxt.tick_cnt = 16'h0000;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 16'h0001;
    end
    unique case (icfg_sync_e'(st_r.misc[MISC_SYNC_HI:MISC_SYNC_LO]))
      SYNC_INTERNAL, SYNC_OUTPUT: src_tick = (st_r.tick_cnt == 16'(TICK_CYC - 1));
      SYNC_DIRECT: src_tick = sync_edge;
      SYNC_SCALED: begin
        // Scaled mode: scale factor ticks after each sync edge, one every 16 core clocks
        if (sync_edge) begin
          st_nxt.scaled_cnt = 32'(st_r.scale);
        end else if (st_r.scaled_cnt != 32'h0000_0000 && st_r.tick_cnt[3:0] == 4'h0) begin
          st_nxt.scaled_cnt = st_r.scaled_cnt - 32'h0000_0001;
          src_tick = 1'b1;
        end
      end
    endcase
    // Decimation divider; paused while a command runs
    if (src_tick && st_r.cmd_st == CM_IDLE) begin
      if (st_r.div_cnt >= st_r.dec[DEC_W-1:0] || st_r.div_cnt >= DEC_MAX) begin
        st_nxt.div_cnt = '0;
        st_nxt.tick = 1'b1;
        st_nxt.drdy = ~st_r.drdy;
        // A stale flag raised in this same cycle wins over the clear
        if (!stale_set) begin
          st_nxt.sync_stale = 1'b0;
        end
      end else begin
        st_nxt.div_cnt = st_r.div_cnt + 11'h001;
      end
    end
    // Command execution
    if (st_r.cmd_st == CM_RUN) begin
      if (st_r.busy_cnt > 32'h0000_0001) begin
        st_nxt.busy_cnt = st_r.busy_cnt - 32'h0000_0001;
      end else begin
        st_nxt.cmd_st = CM_IDLE;
        st_nxt.cmd = '0;
        if (st_r.cmd[CMD_FTEST_BIT]) st_nxt.diag[DIAG_FTEST_BIT] = !flash_crc_ok_i;
        if (st_r.cmd[CMD_FSAVE_BIT]) st_nxt.diag[DIAG_FSAVE_BIT] = !flash_save_ok_i;
        if (st_r.cmd[CMD_STEST_BIT]) st_nxt.diag[DIAG_STEST_BIT] = !self_test_ok_i;
        if (st_r.cmd[CMD_RESTORE_BIT]) begin
          st_nxt.misc = MISC_RST;
          st_nxt.dec = DEC_RST;
          st_nxt.dec_pend = DEC_RST;
          st_nxt.filt = FILT_RST;
          st_nxt.bias_clr = '1;
        end
      end
    end
    if (sys_rst_i || (st_r.cmd_st == CM_RUN && st_r.busy_cnt <= 32'h0000_0001 && st_r.cmd[CMD_RESET_BIT])) begin
      st_nxt = '0;
      st_nxt.misc = MISC_RST;
      st_nxt.scale = SCALE_RST;
      st_nxt.dec = DEC_RST;
      st_nxt.dec_pend = DEC_RST;
      st_nxt.filt = FILT_RST;
      st_nxt.cmd_st = CM_IDLE;
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    st_r <= st_nxt;
  end

  // Outputs; data-ready held while a command runs, output sync keeps running
  assign link.frame_ready = (st_r.cmd_st == CM_IDLE);
  assign link.rd_data = st_r.rd_data;
  assign link.rd_valid = st_r.rd_valid;
  assign link.sample_valid_strobe = st_r.drdy;
  assign link.sync_pin_out = (st_r.tick_cnt < 16'(TICK_CYC / 2));
  assign link.sync_pin_oe_n = !(st_r.misc[MISC_SYNC_HI:MISC_SYNC_LO] == SYNC_OUTPUT);
  assign misc_ctrl_o = st_r.misc;
  assign sync_multiplier_o = (st_r.misc[MISC_SYNC_HI:MISC_SYNC_LO] == SYNC_SCALED) ? st_r.scale : 16'h0001;
  assign decimation_o = st_r.dec[DEC_W-1:0];
  assign gyro_x_offset_low_o = st_r.bias_clr;
  assign sample_tick_o = st_r.tick;
endmodule

// >>> icfg_checker.sv
// Checker watching the frame link between the host and device ends.
// Assumes it sits beside the link interface, one core clock.
`timescale 1ns/1ps
module icfg_checker
  import icfg_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic frame_valid,
  input wire logic frame_ready,
  input wire logic [15:0] frame_data,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic sample_valid_strobe,
  input wire logic sync_pin_in,
  input wire logic sync_pin_out,
  input wire logic sync_pin_oe_n
);
  // ==========
  // Frame decode
  logic take;
  logic cmd_go;
  logic cmd_nop;
  assign take = frame_valid && frame_ready;
  assign cmd_go = take && frame_data[15:8] == 8'hE8 && |(frame_data[7:0] & CMD_USED_MASK);
  assign cmd_nop = take && frame_data[15:8] == 8'hE8 && !(|(frame_data[7:0] & CMD_USED_MASK));
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // ==========
  // Assertions
  chk_frame_hold: assert property (frame_valid && !frame_ready |=> frame_valid && $stable(frame_data))
    else $error("frame not held");
  chk_read_answer: assert property (take && !frame_data[15] |=> rd_valid)
    else $error("read not answered");
  chk_read_cause: assert property (rd_valid |-> $past(take && !frame_data[15]))
    else $error("answer without read");
  chk_read_single: assert property (rd_valid |=> !rd_valid)
    else $error("answer too long");
  chk_cmd_halt: assert property (cmd_go |=> !frame_ready [*8] ##[1:60] frame_ready)
    else $error("command busy wrong");
  chk_cmd_unused: assert property (cmd_nop |=> frame_ready [*3])
    else $error("unused bit started work");
  chk_quiet_strobe: assert property (!frame_ready && $past(!frame_ready) |-> $stable(sample_valid_strobe))
    else $error("strobe during command");
  chk_strobe_gap: assert property ($changed(sample_valid_strobe) |=> $stable(sample_valid_strobe) [*8])
    else $error("strobe too fast");
  // Main scenarios
  cover property (cmd_go);
  cover property (rd_valid);
  cover property (!sync_pin_oe_n && $rose(sync_pin_out));
  cover property (rd_valid && rd_data != 16'h0000);
  cover property ($rose(sync_pin_in));
endmodule

// >>> icfg_tb.sv
// Testbench: APB orders to the host end, device end across the link.
// Assumes package, link interface, both ends and checker compiled first.
`timescale 1ns/1ps
module icfg_tb;
  import icfg_pkg::*;
  logic core_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic crc_ok = 1'b1;
  logic save_ok = 1'b1;
  logic st_ok = 1'b1;
  logic [15:0] misc;
  logic [15:0] mult;
  logic [10:0] dec;
  logic [11:0] offs;
  logic [11:0] offs_seen = 12'h000;
  logic smp_tick;
  int tick_total = 0;
  logic [31:0] rdat;
  logic rerr;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0;
  icfg_link_if link ();
  // Clock
  always #12.5 core_clk_i = ~core_clk_i;
  icfg_host i_icfg_host (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .link(link));
  // Revision value is arbitrary
  icfg_dev #(.CMD_BUSY_CYC(20), .FW_REV(16'h0259)) i_icfg_dev (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .flash_crc_ok_i(crc_ok), .flash_save_ok_i(save_ok), .self_test_ok_i(st_ok), .misc_ctrl_o(misc),
    .sync_multiplier_o(mult), .decimation_o(dec), .gyro_x_offset_low_o(offs), .sample_tick_o(smp_tick),
    .link(link));
  icfg_checker i_icfg_checker (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .frame_valid(link.frame_valid),
    .frame_ready(link.frame_ready), .frame_data(link.frame_data), .rd_data(link.rd_data),
    .rd_valid(link.rd_valid), .sample_valid_strobe(link.sample_valid_strobe), .sync_pin_in(link.sync_pin_in),
    .sync_pin_out(link.sync_pin_out), .sync_pin_oe_n(link.sync_pin_oe_n));
  // ==========
  // Cycle count, hang limit, bias clear capture
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (!sys_rst_i) begin
      offs_seen <= offs_seen | offs;
    end
    if (smp_tick === 1'b1) begin
      tick_total <= tick_total + 1;
    end
    if (cyc == 95000) begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // APB transfer: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait until the link has no frame pending and no command running
  task automatic idle;
    do begin
      @(posedge core_clk_i);
    end while (link.frame_valid !== 1'b0 || link.frame_ready !== 1'b1);
  endtask
  task automatic wr(input logic [15:0] f);
    apb(1'b1, 8'h00, {16'h0, f});
    idle();
  endtask
  task automatic wr2(input logic [6:0] a, input logic [15:0] v);
    wr({1'b1, a, v[7:0]});
    wr({1'b1, a + 7'h1, v[15:8]});
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] m, input logic [15:0] e);
    apb(1'b1, 8'h00, {16'h0, 1'b0, a, 8'h00});
    do begin
      @(posedge core_clk_i);
    end while (link.rd_valid !== 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    check({16'h0, rdat[15:0] & m}, {16'h0, e & m});
  endtask
  task automatic cmd(input logic [7:0] c, input logic [15:0] m, input logic [15:0] e);
    wr({8'hE8, c});
    wr(16'hE900);
    rd(ADDR_DIAG_LO, m, e);
  endtask
  task automatic tog;
    logic s;
    s = link.sample_valid_strobe;
    do begin
      @(posedge core_clk_i);
    end while (link.sample_valid_strobe === s);
  endtask
  // ==========
  // Test sequence
  initial begin
    repeat (6) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge core_clk_i);
    rd(ADDR_MISC_LO, 16'h00C0, 16'h00C0);
    rd(ADDR_SCALE_LO, 16'hFFFF, 16'h07D0);
    rd(ADDR_DEC_LO, 16'h07FF, 16'h0000);
    wr2(ADDR_REV_LO, 16'h1111);
    rd(ADDR_REV_LO, 16'hFFFF, 16'h0259);
    apb(1'b1, 8'h10, 32'h0);
    check({31'h0, rerr}, 32'h1);
    $display("defaults done");
    wr(16'hE081);
    wr(16'hE100);
    check({16'h0, misc}, 32'h0081);
    wr(16'hE041);
    wr(16'hEF00);
    check({16'h0, misc}, 32'h0041);
    wr2(ADDR_SCALE_LO, 16'h1234);
    rd(ADDR_SCALE_LO, 16'hFFFF, 16'h0000);
    wr2(ADDR_DEC_LO, 16'hFFCF);
    repeat (1200) @(posedge core_clk_i);
    check({21'h0, dec}, 32'h07CF);
    wr2(ADDR_DEC_LO, 16'h0001);
    repeat (1200) @(posedge core_clk_i);
    rd(ADDR_DEC_LO, 16'h07FF, 16'h0001);
    tog();
    t0 = cyc;
    rd(ADDR_SCALE_LO, 16'hFFFF, 16'h1234);
    tog();
    check(32'(cyc - t0), 32'(2 * TICK_CYC));
    $display("rate done");
    for (int m = 0; m < 4; m++) begin
      wr2(ADDR_MISC_LO, {8'h00, 4'h4, m[1:0], 2'b01});
      check({16'h0, mult}, (m == 2) ? 32'h1234 : 32'h1);
      check({31'h0, link.sync_pin_oe_n}, {31'h0, m != 3});
      // Direct mode: two sync edges with decimation 1 give one sample
      if (m == 1) begin
        t0 = tick_total;
        repeat (2) begin
          apb(1'b1, 8'h0C, 32'h1);
          apb(1'b1, 8'h0C, 32'h0);
        end
        repeat (2) @(posedge core_clk_i);
        check(32'(tick_total - t0), 32'h1);
      end
    end
    wr2(ADDR_MISC_LO, 16'h0041);
    $display("sync modes done");
    crc_ok <= 1'b0;
    save_ok <= 1'b0;
    st_ok <= 1'b0;
    cmd(8'h10, 16'h0040, 16'h0040);
    cmd(8'h08, 16'h0004, 16'h0004);
    save_ok <= 1'b1;
    cmd(8'h08, 16'h0004, 16'h0000);
    apb(1'b1, 8'h00, 32'hE804);
    apb(1'b1, 8'h00, 32'hE900);
    apb(1'b1, 8'h00, 32'hE900);
    check({31'h0, rerr}, 32'h1);
    idle();
    rd(ADDR_DIAG_LO, 16'h0020, 16'h0020);
    wr(16'hE861);
    wr(16'hE900);
    check({16'h0, misc}, 32'h0041);
    $display("commands done");
    wr(16'hE802);
    wr(16'hE900);
    check({16'h0, misc}, 32'h00C1);
    check({21'h0, dec}, 32'h0);
    check({20'h0, offs_seen}, 32'hFFF);
    wr2(ADDR_MISC_LO, 16'h0081);
    wr2(ADDR_DEC_LO, 16'h0005);
    repeat (1200) @(posedge core_clk_i);
    wr(16'hE880);
    wr(16'hE900);
    check({16'h0, misc}, 32'h00C1);
    check({21'h0, dec}, 32'h0);
    $display("restore and reset done");
    wrap_up();
  end
endmodule
